// ==== rtl/srs_pkg.sv ====
/*
  Shared constants, types and message decode for the span startup
  sequencer: segment messages, segment states and clock modes.
  Assumes one clock and a synchronous active-high reset everywhere.
*/
package srs_pkg;

  ////////////////////////////////////////////////////////////////////
  // Widths, counts and limits
  localparam int CAPS_W = 8;
  localparam int ACT_W = 4;
  localparam int MAX_REGEN = 8;
  // Activation stand-in length: 16 cycles, counted 0..15
  localparam logic [ACT_W-1:0] ACT_LAST = 4'hF;
  localparam logic [ACT_W-1:0] ACT_ZERO = 4'h0;
  localparam logic [CAPS_W-1:0] CAPS_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////
  // Handshake steps of the initiating unit
  localparam logic [2:0] STEP_CAPS1 = 3'h0;
  localparam logic [2:0] STEP_WCAPS1 = 3'h1;
  localparam logic [2:0] STEP_WPROBE = 3'h2;
  localparam logic [2:0] STEP_WCAPS2 = 3'h3;
  localparam logic [2:0] STEP_WMS = 3'h4;

  ////////////////////////////////////////////////////////////////////
  // Segment messages, one-cycle pulses
  typedef enum logic [2:0] {
    MSG_NONE = 3'h0,
    MSG_START = 3'h1,
    MSG_CAPS = 3'h2,
    MSG_PROBE = 3'h3,
    MSG_END = 3'h4,
    MSG_MS = 3'h5,
    MSG_GO = 3'h6,
    MSG_ACT = 3'h7
  } srs_kind_t;

  // Segment state as seen by one unit
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_HANDSHAKE = 3'h1,
    ST_HELD = 3'h2,
    ST_ACTIVATE = 3'h3,
    ST_OPER = 3'h4
  } srs_state_t;

  typedef enum logic [1:0] {
    CM_1 = 2'h0,
    CM_2 = 2'h1,
    CM_3A = 2'h2,
    CM_3B = 2'h3
  } srs_clk_mode_t;

  // True when a valid message of the wanted kind arrives
  function automatic logic msg_is(input logic v, input srs_kind_t got,
                                  input srs_kind_t want);
    return v && (got == want);
  endfunction

endpackage : srs_pkg

// ==== rtl/srs_seg_if.sv ====
/*
  One segment between two units: a message lane in each direction.
  Assumes both ends share clk and reset; the bench joins the ends.
*/
interface srs_seg_if
  import srs_pkg::*;
(
  input logic clk,
  input logic reset
);
  // Regenerator half to peer
  logic dev_valid;
  srs_kind_t dev_kind;
  logic [CAPS_W-1:0] dev_data;
  logic dev_silent;
  // Peer to regenerator half
  logic oth_valid;
  srs_kind_t oth_kind;
  logic [CAPS_W-1:0] oth_data;
  logic oth_silent;

  modport dev (
    input clk, reset, oth_valid, oth_kind, oth_data, oth_silent,
    output dev_valid, dev_kind, dev_data, dev_silent
  );
  modport oth (
    input clk, reset, dev_valid, dev_kind, dev_data, dev_silent,
    output oth_valid, oth_kind, oth_data, oth_silent
  );
endinterface : srs_seg_if

// ==== rtl/srs_regen_half.sv ====
/*
  One regenerator half: faces one segment and talks to its twin half
  over the internal handoff lanes. facing_remote picks the role.
  Assumes the peer on the segment keeps the message order and that
  the twin half is wired back to back on the handoff lanes.
*/
// Notes on behaviour
// - Up to eight regenerators, every segment alike.
// - Capabilities go centralward, training goes remoteward.
// - Silent bit holds a segment while others proceed.
// - Remote terminal opens the first session.
// - Capabilities, optional probe, second capabilities exchange.
// - Lacking information, answer mode select with silent.
// - Session ends after silent answer; initiator waits.
// - Held half passes capabilities to twin half.
// - Advertise own capabilities ANDed with received.
// - Central terminal selects parameters, starts activation.
// - Pass parameters after activation; mode 1 session.
// - Selected parameters skip further capability exchange.
// - Mode 1 needs no symbol timing lock.
// - Mode 1 next session starts at session end.
// - Other modes wait for previous activation end.
// - Span operational after final segment activates; span_up here rises when this half's own segment activates.
module srs_regen_half
  import srs_pkg::*;
(
  srs_seg_if.dev seg,
  input logic facing_remote,
  input srs_clk_mode_t clock_mode,
  input logic probe_en,
  input logic [CAPS_W-1:0] own_caps,
  input logic peer_valid,
  input logic peer_is_params,
  input logic [CAPS_W-1:0] peer_data,
  input logic peer_done,
  output logic xfer_valid,
  output logic xfer_is_params,
  output logic [CAPS_W-1:0] xfer_data,
  output logic xfer_done,
  output srs_state_t seg_state,
  output logic [CAPS_W-1:0] params,
  output logic span_up,
  output logic timing_lock_req
);

  ////////////////////////////////////////////////////////////////////
  // State
  srs_state_t state;
  logic [2:0] step;
  logic initiator;
  logic [CAPS_W-1:0] adv;
  logic [CAPS_W-1:0] rx_caps;
  logic [ACT_W-1:0] act_cnt;
  logic tx_valid;
  srs_kind_t tx_kind;
  logic [CAPS_W-1:0] tx_data;
  logic tx_silent;

  ////////////////////////////////////////////////////////////////////
  // Message decode
  wire rx_start = msg_is(seg.oth_valid, seg.oth_kind, MSG_START);
  wire rx_caps_m = msg_is(seg.oth_valid, seg.oth_kind, MSG_CAPS);
  wire rx_probe = msg_is(seg.oth_valid, seg.oth_kind, MSG_PROBE);
  wire rx_end = msg_is(seg.oth_valid, seg.oth_kind, MSG_END);
  wire rx_ms = msg_is(seg.oth_valid, seg.oth_kind, MSG_MS);
  wire rx_go = msg_is(seg.oth_valid, seg.oth_kind, MSG_GO);
  wire rx_act = msg_is(seg.oth_valid, seg.oth_kind, MSG_ACT);
  wire mode1 = (clock_mode == CM_1);
  // Twin half hands over capabilities or chosen parameters
  wire caps_in = peer_valid && !peer_is_params;
  // Without mode 1 the twin must report a finished activation, so
  // that a reference clock exists before this segment trains
  wire params_in = peer_valid && peer_is_params
                   && (mode1 || peer_done);
  // Responder times activation; initiator waits for its report
  wire act_fin = initiator ? rx_act : (act_cnt == ACT_LAST);

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign seg.dev_valid = tx_valid;
  assign seg.dev_kind = tx_kind;
  assign seg.dev_data = tx_data;
  assign seg.dev_silent = tx_silent;
  assign seg_state = state;
  assign span_up = (state == ST_OPER);
  // Only clock modes 2, 3a and 3b lock to a reference
  assign timing_lock_req = (state == ST_ACTIVATE) && !mode1;

  ////////////////////////////////////////////////////////////////////
  // Startup sequencer; the same for every segment of the span
  always_ff @(posedge seg.clk) begin
    if (seg.reset) begin
      state <= ST_IDLE;
      step <= STEP_CAPS1;
      initiator <= 1'b0;
      adv <= CAPS_ZERO;
      rx_caps <= CAPS_ZERO;
      params <= CAPS_ZERO;
      act_cnt <= ACT_ZERO;
      tx_valid <= 1'b0;
      tx_kind <= MSG_NONE;
      tx_data <= CAPS_ZERO;
      tx_silent <= 1'b0;
      xfer_valid <= 1'b0;
      xfer_is_params <= 1'b0;
      xfer_data <= CAPS_ZERO;
      xfer_done <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      xfer_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (facing_remote && rx_start) begin
            state <= ST_HANDSHAKE;
            initiator <= 1'b0;
          end else if (!facing_remote && caps_in) begin
            adv <= own_caps & peer_data;
            tx_valid <= 1'b1;
            tx_kind <= MSG_START;
            tx_silent <= 1'b0;
            state <= ST_HANDSHAKE;
            initiator <= 1'b1;
            step <= STEP_CAPS1;
          end
        end
        ST_HANDSHAKE: begin
          if (!initiator) begin
            // Answering side of a capabilities session
            if (rx_caps_m) begin
              rx_caps <= seg.oth_data;
              tx_valid <= 1'b1;
              tx_kind <= MSG_CAPS;
              tx_data <= own_caps;
            end else if (rx_probe) begin
              tx_valid <= 1'b1;
              tx_kind <= MSG_PROBE;
            end else if (rx_end) begin
              // Too early to activate: hold the initiator off
              tx_valid <= 1'b1;
              tx_kind <= MSG_MS;
              tx_data <= rx_caps;
              tx_silent <= 1'b1;
              state <= ST_HELD;
              xfer_valid <= 1'b1;
              xfer_is_params <= 1'b0;
              xfer_data <= rx_caps;
              xfer_done <= 1'b0;
            end
          end else begin
            case (step)
              STEP_CAPS1: begin
                tx_valid <= 1'b1;
                tx_kind <= MSG_CAPS;
                tx_data <= adv;
                step <= STEP_WCAPS1;
              end
              STEP_WCAPS1: begin
                if (rx_caps_m) begin
                  tx_valid <= 1'b1;
                  tx_kind <= probe_en ? MSG_PROBE : MSG_END;
                  step <= probe_en ? STEP_WPROBE : STEP_WMS;
                end
              end
              STEP_WPROBE: begin
                if (rx_probe) begin
                  tx_valid <= 1'b1;
                  tx_kind <= MSG_CAPS;
                  tx_data <= adv;
                  step <= STEP_WCAPS2;
                end
              end
              STEP_WCAPS2: begin
                if (rx_caps_m) begin
                  tx_valid <= 1'b1;
                  tx_kind <= MSG_END;
                  step <= STEP_WMS;
                end
              end
              STEP_WMS: begin
                if (rx_ms && seg.oth_silent) begin
                  state <= ST_HELD;
                end else if (rx_ms) begin
                  params <= seg.oth_data;
                  state <= ST_ACTIVATE;
                  act_cnt <= ACT_ZERO;
                  // Mode 1: session end is enough to hand over
                  if (mode1 && !facing_remote) begin
                    xfer_valid <= 1'b1;
                    xfer_is_params <= 1'b1;
                    xfer_data <= seg.oth_data;
                    xfer_done <= 1'b0;
                  end
                end
              end
              default: begin
                step <= STEP_CAPS1;
              end
            endcase
          end
        end
        ST_HELD: begin
          if (facing_remote && params_in) begin
            // Parameters already chosen: no capabilities this time
            params <= peer_data;
            tx_valid <= 1'b1;
            tx_kind <= MSG_GO;
            tx_data <= peer_data;
            tx_silent <= 1'b0;
            state <= ST_HANDSHAKE;
            initiator <= 1'b1;
            step <= STEP_WMS;
          end else if (!facing_remote && rx_go) begin
            params <= seg.oth_data;
            tx_valid <= 1'b1;
            tx_kind <= MSG_MS;
            tx_data <= seg.oth_data;
            tx_silent <= 1'b0;
            state <= ST_ACTIVATE;
            initiator <= 1'b0;
            act_cnt <= ACT_ZERO;
            if (mode1) begin
              xfer_valid <= 1'b1;
              xfer_is_params <= 1'b1;
              xfer_data <= seg.oth_data;
              xfer_done <= 1'b0;
            end
          end
        end
        ST_ACTIVATE: begin
          act_cnt <= act_cnt + 4'h1;
          if (act_fin) begin
            state <= ST_OPER;
            if (!initiator) begin
              tx_valid <= 1'b1;
              tx_kind <= MSG_ACT;
            end
            // Other modes hand over only once training is done
            if (!mode1 && !facing_remote) begin
              xfer_valid <= 1'b1;
              xfer_is_params <= 1'b1;
              xfer_data <= params;
              xfer_done <= 1'b1;
            end
          end
        end
        ST_OPER: begin
          state <= ST_OPER;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // srs_regen_half

// ==== rtl/srs_terminal.sv ====
/*
  Terminal unit at one end of the span: remote terminal when
  is_central is low, central terminal when high.
  Assumes the regenerator half across the segment keeps the order.
*/
module srs_terminal
  import srs_pkg::*;
(
  srs_seg_if.oth seg,
  input logic is_central,
  input logic start_req,
  input logic probe_en,
  input logic [CAPS_W-1:0] own_caps,
  output srs_state_t seg_state,
  output logic [CAPS_W-1:0] params,
  output logic span_up
);

  ////////////////////////////////////////////////////////////////////
  // State
  srs_state_t state;
  logic [2:0] step;
  logic initiator;
  logic [CAPS_W-1:0] rx_caps;
  logic [ACT_W-1:0] act_cnt;
  logic tx_valid;
  srs_kind_t tx_kind;
  logic [CAPS_W-1:0] tx_data;
  logic tx_silent;

  ////////////////////////////////////////////////////////////////////
  // Message decode
  wire rx_start = msg_is(seg.dev_valid, seg.dev_kind, MSG_START);
  wire rx_caps_m = msg_is(seg.dev_valid, seg.dev_kind, MSG_CAPS);
  wire rx_probe = msg_is(seg.dev_valid, seg.dev_kind, MSG_PROBE);
  wire rx_end = msg_is(seg.dev_valid, seg.dev_kind, MSG_END);
  wire rx_ms = msg_is(seg.dev_valid, seg.dev_kind, MSG_MS);
  wire rx_go = msg_is(seg.dev_valid, seg.dev_kind, MSG_GO);
  wire rx_act = msg_is(seg.dev_valid, seg.dev_kind, MSG_ACT);
  wire act_fin = initiator ? rx_act : (act_cnt == ACT_LAST);
  // Central picks own caps ANDed with the caps received on its segment
  wire [CAPS_W-1:0] chosen = own_caps & rx_caps;

  assign seg.oth_valid = tx_valid;
  assign seg.oth_kind = tx_kind;
  assign seg.oth_data = tx_data;
  assign seg.oth_silent = tx_silent;
  assign seg_state = state;
  assign span_up = (state == ST_OPER);

  ////////////////////////////////////////////////////////////////////
  // Terminal sequencer
  always_ff @(posedge seg.clk) begin
    if (seg.reset) begin
      state <= ST_IDLE;
      step <= STEP_CAPS1;
      initiator <= 1'b0;
      rx_caps <= CAPS_ZERO;
      params <= CAPS_ZERO;
      act_cnt <= ACT_ZERO;
      tx_valid <= 1'b0;
      tx_kind <= MSG_NONE;
      tx_data <= CAPS_ZERO;
      tx_silent <= 1'b0;
    end else begin
      tx_valid <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (is_central && rx_start) begin
            state <= ST_HANDSHAKE;
            initiator <= 1'b0;
          end else if (!is_central && start_req) begin
            tx_valid <= 1'b1;
            tx_kind <= MSG_START;
            tx_silent <= 1'b0;
            state <= ST_HANDSHAKE;
            initiator <= 1'b1;
            step <= STEP_CAPS1;
          end
        end
        ST_HANDSHAKE: begin
          if (!initiator) begin
            if (rx_caps_m) begin
              rx_caps <= seg.dev_data;
              tx_valid <= 1'b1;
              tx_kind <= MSG_CAPS;
              tx_data <= own_caps;
            end else if (rx_probe) begin
              tx_valid <= 1'b1;
              tx_kind <= MSG_PROBE;
            end else if (rx_end) begin
              params <= chosen;
              tx_valid <= 1'b1;
              tx_kind <= MSG_MS;
              tx_data <= chosen;
              tx_silent <= 1'b0;
              state <= ST_ACTIVATE;
              act_cnt <= ACT_ZERO;
            end
          end else begin
            case (step)
              STEP_CAPS1: begin
                tx_valid <= 1'b1;
                tx_kind <= MSG_CAPS;
                tx_data <= own_caps;
                step <= STEP_WCAPS1;
              end
              STEP_WCAPS1: begin
                if (rx_caps_m) begin
                  tx_valid <= 1'b1;
                  tx_kind <= probe_en ? MSG_PROBE : MSG_END;
                  step <= probe_en ? STEP_WPROBE : STEP_WMS;
                end
              end
              STEP_WPROBE: begin
                if (rx_probe) begin
                  tx_valid <= 1'b1;
                  tx_kind <= MSG_CAPS;
                  tx_data <= own_caps;
                  step <= STEP_WCAPS2;
                end
              end
              STEP_WCAPS2: begin
                if (rx_caps_m) begin
                  tx_valid <= 1'b1;
                  tx_kind <= MSG_END;
                  step <= STEP_WMS;
                end
              end
              STEP_WMS: begin
                if (rx_ms && seg.dev_silent) begin
                  state <= ST_HELD;
                end else if (rx_ms) begin
                  params <= seg.dev_data;
                  state <= ST_ACTIVATE;
                  act_cnt <= ACT_ZERO;
                end
              end
              default: begin
                step <= STEP_CAPS1;
              end
            endcase
          end
        end
        ST_HELD: begin
          // Waiting period until training reaches this end
          if (rx_go) begin
            params <= seg.dev_data;
            tx_valid <= 1'b1;
            tx_kind <= MSG_MS;
            tx_data <= seg.dev_data;
            tx_silent <= 1'b0;
            state <= ST_ACTIVATE;
            initiator <= 1'b0;
            act_cnt <= ACT_ZERO;
          end
        end
        ST_ACTIVATE: begin
          act_cnt <= act_cnt + 4'h1;
          if (act_fin) begin
            state <= ST_OPER;
            if (!initiator) begin
              tx_valid <= 1'b1;
              tx_kind <= MSG_ACT;
            end
          end
        end
        ST_OPER: begin
          state <= ST_OPER;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

endmodule // srs_terminal

// ==== verification/srs_seg_properties.sv ====
/*
  Concurrent checks on the segment between the remote terminal and
  the regenerator half that faces it.
  Assumes one clock, a synchronous active-high reset, and that the
  bench hands over the interface signals one by one.
*/
module srs_seg_properties
  import srs_pkg::*;
(
  input logic clk,
  input logic reset,
  input logic dev_valid,
  input srs_kind_t dev_kind,
  input logic [CAPS_W-1:0] dev_data,
  input logic dev_silent,
  input logic oth_valid,
  input srs_kind_t oth_kind,
  input logic [CAPS_W-1:0] oth_data,
  input logic oth_silent
);
  timeunit 1ns;
  timeprecision 1ns;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////
  // Named message strobes, one per kind in use
  wire o_start = oth_valid && (oth_kind == MSG_START);
  wire o_caps = oth_valid && (oth_kind == MSG_CAPS);
  wire o_probe = oth_valid && (oth_kind == MSG_PROBE);
  wire o_end = oth_valid && (oth_kind == MSG_END);
  wire o_ms = oth_valid && (oth_kind == MSG_MS);
  wire o_act = oth_valid && (oth_kind == MSG_ACT);
  wire d_caps = dev_valid && (dev_kind == MSG_CAPS);
  wire d_probe = dev_valid && (dev_kind == MSG_PROBE);
  wire d_ms = dev_valid && (dev_kind == MSG_MS);
  wire d_go = dev_valid && (dev_kind == MSG_GO);

  ////////////////////////////////////////////////////////////////////
  // Capability session opened by the remote terminal
  property p_start_caps;
    o_start |=> o_caps;
  endproperty
  a_start_caps: assert property (p_start_caps)
    else $error("start not followed by capabilities");
  property p_caps_answer;
    o_caps |=> d_caps;
  endproperty
  a_caps_answer: assert property (p_caps_answer)
    else $error("capabilities not answered next cycle");
  property p_probe_answer;
    o_probe |=> d_probe;
  endproperty
  a_probe_answer: assert property (p_probe_answer)
    else $error("probe not answered next cycle");
  // Regenerator half never knows enough here, so it must hold off
  property p_end_hold;
    o_end |=> d_ms && dev_silent;
  endproperty
  a_end_hold: assert property (p_end_hold)
    else $error("session end not answered by silent mode select");
  property p_quiet;
    d_ms && dev_silent |=> !(oth_valid || dev_valid) until d_go;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("traffic on a held segment");
  // Bound on the wait, since until alone never fails on a hang
  property p_go_bound;
    d_ms && dev_silent |-> ##[1:300] d_go;
  endproperty
  a_go_bound: assert property (p_go_bound)
    else $error("held segment never restarted");

  ////////////////////////////////////////////////////////////////////
  // Parameter session and activation toward the remote terminal
  property p_go_reply;
    d_go |=> o_ms && !oth_silent;
  endproperty
  a_go_reply: assert property (p_go_reply)
    else $error("selected parameters not met by plain mode select");
  property p_act_time;
    o_ms && !oth_silent |-> ##[16:17] o_act;
  endproperty
  a_act_time: assert property (p_act_time)
    else $error("activation did not end on time");
  property p_no_regen_start;
    dev_valid |-> dev_kind != MSG_START;
  endproperty
  a_no_regen_start: assert property (p_no_regen_start)
    else $error("regenerator opened a capability session remoteward");
  property p_no_remote_go;
    oth_valid |-> oth_kind != MSG_GO;
  endproperty
  a_no_remote_go: assert property (p_no_remote_go)
    else $error("remote terminal sent parameters");

  c_probe: cover property (o_probe);
endmodule // srs_seg_properties

// ==== verification/regenerator_span_startup_sequencer_tb.sv ====
/*
  Self-checking bench: remote terminal, one regenerator made of two
  halves, and the central terminal, joined by two segments.
  Assumes the message order and 16-cycle activation of the design.
*/
module regenerator_span_startup_sequencer_tb
  import srs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic start_req = 1'b0;
  logic probe_en = 1'b0;
  srs_clk_mode_t mode = CM_1;
  logic [CAPS_W-1:0] caps_t = CAPS_ZERO, caps_hr = CAPS_ZERO;
  logic [CAPS_W-1:0] caps_hc = CAPS_ZERO, caps_c = CAPS_ZERO;
  logic hr_xv, hr_xp, hr_xd, hc_xv, hc_xp, hc_xd;
  logic [CAPS_W-1:0] hr_xdat, hc_xdat, par_t, par_hr, par_hc, par_c;
  srs_state_t st_t, st_hr, st_hc, st_c;
  logic up_t, up_hr, up_hc, up_c, lock_hr, lock_hc;
  logic up_t_d = 1'b0;
  logic lock_seen = 1'b0;
  logic [12:0] notes[$];
  int fail_count = 0;
  int n_compared = 0;
  int cycles = 0;
  integer seed = 32'h9272;

  always #10 clk = ~clk;

  ////////////////////////////////////////////////////////////////////
  // Span: remote terminal, regenerator halves back to back, central
  srs_seg_if seg_r (.clk(clk), .reset(reset));
  srs_seg_if seg_c (.clk(clk), .reset(reset));
  srs_terminal i_srs_terminal_r (.seg(seg_r), .is_central(1'b0),
    .start_req(start_req), .probe_en(probe_en), .own_caps(caps_t),
    .seg_state(st_t), .params(par_t), .span_up(up_t));
  srs_regen_half i_srs_regen_half_r (.seg(seg_r), .facing_remote(1'b1),
    .clock_mode(mode), .probe_en(probe_en), .own_caps(caps_hr),
    .peer_valid(hc_xv), .peer_is_params(hc_xp), .peer_data(hc_xdat),
    .peer_done(hc_xd), .xfer_valid(hr_xv), .xfer_is_params(hr_xp),
    .xfer_data(hr_xdat), .xfer_done(hr_xd), .seg_state(st_hr),
    .params(par_hr), .span_up(up_hr), .timing_lock_req(lock_hr));
  srs_regen_half i_srs_regen_half_c (.seg(seg_c), .facing_remote(1'b0),
    .clock_mode(mode), .probe_en(probe_en), .own_caps(caps_hc),
    .peer_valid(hr_xv), .peer_is_params(hr_xp), .peer_data(hr_xdat),
    .peer_done(hr_xd), .xfer_valid(hc_xv), .xfer_is_params(hc_xp),
    .xfer_data(hc_xdat), .xfer_done(hc_xd), .seg_state(st_hc),
    .params(par_hc), .span_up(up_hc), .timing_lock_req(lock_hc));
  srs_terminal i_srs_terminal_c (.seg(seg_c), .is_central(1'b1),
    .start_req(1'b0), .probe_en(probe_en), .own_caps(caps_c),
    .seg_state(st_c), .params(par_c), .span_up(up_c));
  srs_seg_properties i_srs_seg_properties (.clk(clk), .reset(reset),
    .dev_valid(seg_r.dev_valid), .dev_kind(seg_r.dev_kind),
    .dev_data(seg_r.dev_data), .dev_silent(seg_r.dev_silent),
    .oth_valid(seg_r.oth_valid), .oth_kind(seg_r.oth_kind),
    .oth_data(seg_r.oth_data), .oth_silent(seg_r.oth_silent));

  ////////////////////////////////////////////////////////////////////
  // Comparison, note taking and the verdict
  task automatic compare(input logic [12:0] seen, input logic [12:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // An empty queue means an unexpected result: force a mismatch
  task automatic take(input logic [12:0] seen);
    logic [12:0] exp;
    exp = ~seen;
    if (notes.size() > 0) exp = notes.pop_front();
    compare(seen, exp);
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watcher: handoffs, the restart toward remote and span up
  always @(posedge clk) begin
    if (reset === 1'b0) begin
      if (hr_xv === 1'b1) take({3'h0, hr_xp, hr_xd, hr_xdat});
      if (hc_xv === 1'b1) take({3'h0, hc_xp, hc_xd, hc_xdat});
      if (seg_r.dev_valid === 1'b1 && seg_r.dev_kind === MSG_GO)
        take({st_c, 2'b00, seg_r.dev_data});
      if (up_t === 1'b1 && up_t_d === 1'b0)
        take({up_c, up_hc, lock_hr, 2'b00, par_t});
      // Sticky: lock request is only high while that half trains
      if (lock_hc === 1'b1) lock_seen <= 1'b1;
    end else begin
      lock_seen <= 1'b0;
    end
    up_t_d <= up_t;
  end

  // Hang guard, well above eight full startups
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fail_count++;
      $display("FAIL %0t: run did not finish", $time);
      results();
    end
  end

  ////////////////////////////////////////////////////////////////////
  // One startup from reset; remote caps kept inside the regenerator's
  // own, so either reading of its handoff gives the same answer
  task automatic run_test(input int i);
    logic [CAPS_W-1:0] p;
    int n;
    reset = 1'b1;
    mode = srs_clk_mode_t'(i[1:0]);
    probe_en = i[2];
    caps_hr = 8'($random(seed));
    caps_t = caps_hr & 8'($random(seed));
    caps_hc = 8'($random(seed));
    caps_c = 8'($random(seed));
    p = caps_t & caps_hc & caps_c;
    repeat (10) @(posedge clk);
    #2 reset = 1'b0;
    compare({st_t, st_hr, st_hc, st_c, up_t}, 13'h0000);
    notes.push_back({5'h00, caps_t});
    notes.push_back({3'h0, 1'b1, mode != CM_1, p});
    notes.push_back({(mode == CM_1) ? ST_ACTIVATE : ST_OPER, 2'b00, p});
    notes.push_back({1'b1, 1'b1, mode != CM_1, 2'b00, p});
    start_req = 1'b1;
    @(posedge clk);
    #2 start_req = 1'b0;
    for (n = 0; n < 400 && up_t !== 1'b1; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    #2 compare(13'(notes.size()), 13'h0000);
    // Every unit ends up running with the same chosen parameters
    compare({up_hr, lock_hc, 3'h0, par_hr}, {2'b10, 3'h0, p});
    compare({12'h000, lock_seen}, {12'h000, mode != CM_1});
    compare({5'h00, par_hc}, {5'h00, p});
    compare({5'h00, par_c}, {5'h00, p});
    $display("test %0d mode %0d probe %0b ended", i, i[1:0], i[2]);
  endtask

  // Every clock mode, with and without the line probe
  initial begin
    for (int i = 0; i < 8; i++) run_test(i);
    results();
  end
endmodule // regenerator_span_startup_sequencer_tb
